// ==== smr_pkg.sv ====
// Package for the shift, move and return execution unit.
// Assumes one 50 MHz clock; shared by the unit and its register bus.
package smr_pkg;
  // Opcode codes written by software into the command register
  typedef enum logic [2:0] {
    smr_nop = 3'h0,
    smr_lsl = 3'h1,
    smr_lsr = 3'h2,
    smr_rlc = 3'h3,
    smr_mov = 3'h4,
    smr_rfi = 3'h5,
    smr_ret = 3'h6,
    smr_rlw = 3'h7
  } smr_op_e;

  // Byte addresses of the APB registers
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_FILE = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_TOS = 8'h14;
  localparam logic [7:0] ADDR_IRQCTL = 8'h18;

  // Command register field positions
  localparam int CMD_OP_LO = 0;
  localparam int CMD_OP_HI = 2;
  localparam int CMD_DEST = 3;
  localparam int CMD_LIT_LO = 8;
  localparam int CMD_LIT_HI = 15;

  // Status and control bit positions
  localparam int STAT_C = 0;
  localparam int STAT_Z = 1;
  localparam int STAT_BUSY = 2;
  localparam int GIE_BIT = 7;

  // Return instructions take two cycles
  localparam logic [1:0] RET_CYCLES = 2'h2;
  localparam int PC_W = 15;

  // Decoded command carried between bus and execute logic
  typedef struct packed {
    smr_op_e op;
    logic dest;
    logic [7:0] lit;
  } smr_cmd_s;
endpackage

// ==== smr_core.sv ====
// Execution unit for shift, rotate, move and return instructions.
// Assumes an APB master on pclk; one command is issued per command write made while no return is running.
// Summary of operation
// [RULE_01] Left shift: bit7 to carry, zero in
// [RULE_02] Right shift: bit0 to carry, zero in
// [RULE_03] Destination 0 accumulator, 1 file register
// [RULE_04] Rotate left through carry, only carry changes
// [RULE_05] Move file copies and updates zero
// [RULE_06] Interrupt return pops, loads pc, sets enable
// [RULE_07] Plain return pops, loads pc, two cycles
// [RULE_08] Literal return loads accumulator, pops, two cycles
// [RULE_09] Zero flag set when result is zero
`timescale 1ns/10ps
`default_nettype none
module smr_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic global_irq_enable,
  output logic busy
);
  // Architectural state
  logic [7:0] file_reg; // Addressed file register
  logic [7:0] acc; // Accumulator
  logic carry; // Carry flag
  logic zero; // Zero flag
  logic [smr_pkg::PC_W-1:0] pc; // Program counter
  logic [smr_pkg::PC_W-1:0] stack_top_value; // Top of return stack
  logic [7:0] irq_control_reg; // Interrupt control, bit 7 is global enable
  logic [1:0] ret_cnt; // Cycles left of a return
  smr_pkg::smr_cmd_s cmd; // Command in progress

  // Bus decode
  logic acc_phase;
  logic wr_en;
  logic cmd_wr;
  logic [7:0] res;
  logic next_c;
  logic mapped;
  logic ret_cmd; // Command word names one of the three returns
  assign acc_phase = psel && penable;
  assign wr_en = acc_phase && pwrite;
  // Opcodes from the interrupt return upwards are the two-cycle returns
  assign ret_cmd = pwdata[smr_pkg::CMD_OP_HI:smr_pkg::CMD_OP_LO] >= smr_pkg::smr_rfi;
  // Commands are refused while a return is still running
  assign cmd_wr = wr_en && paddr == smr_pkg::ADDR_CMD && ret_cnt == 2'h0;

  // Combinational result of single-cycle ops
  always_comb begin
    res = file_reg;
    next_c = carry;
    unique case (smr_pkg::smr_op_e'(pwdata[smr_pkg::CMD_OP_HI:smr_pkg::CMD_OP_LO]))
      smr_pkg::smr_lsl: begin
        res = {file_reg[6:0], 1'b0}; // [RULE_01]
        next_c = file_reg[7]; // [RULE_01]
      end
      smr_pkg::smr_lsr: begin
        res = {1'b0, file_reg[7:1]}; // [RULE_02]
        next_c = file_reg[0]; // [RULE_02]
      end
      smr_pkg::smr_rlc: begin
        res = {file_reg[6:0], carry}; // [RULE_04]
        next_c = file_reg[7]; // [RULE_04]
      end
      default: begin
        res = file_reg; // Move passes the value through [RULE_05]
        next_c = carry;
      end
    endcase
  end

  // Register writes, destination select and flags
  // The single-cycle ops finish at the command edge itself; the sequencer still copies them into cmd but starts no count for them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_reg <= 8'h00;
      acc <= 8'h00;
      carry <= 1'b0;
      zero <= 1'b0;
    end else if (cmd_wr) begin
      unique case (smr_pkg::smr_op_e'(pwdata[smr_pkg::CMD_OP_HI:smr_pkg::CMD_OP_LO]))
        smr_pkg::smr_lsl, smr_pkg::smr_lsr, smr_pkg::smr_rlc, smr_pkg::smr_mov: begin
          if (pwdata[smr_pkg::CMD_DEST]) begin
            file_reg <= res; // [RULE_03]
          end else begin
            acc <= res; // [RULE_03]
          end
          carry <= next_c;
          // Rotate leaves zero alone [RULE_04]
          if (pwdata[smr_pkg::CMD_OP_HI:smr_pkg::CMD_OP_LO] != smr_pkg::smr_rlc) begin
            zero <= (res == 8'h00); // [RULE_09] [RULE_05]
          end
        end
        smr_pkg::smr_rlw: begin
          acc <= pwdata[smr_pkg::CMD_LIT_HI:smr_pkg::CMD_LIT_LO]; // [RULE_08]
        end
        default: begin
          // Plain returns leave flags untouched [RULE_07]
        end
      endcase
    end else if (wr_en && paddr == smr_pkg::ADDR_FILE) begin
      file_reg <= pwdata[7:0];
    end else if (wr_en && paddr == smr_pkg::ADDR_ACC) begin
      acc <= pwdata[7:0];
    end
  end

  // Return sequencer: pops on the second cycle
  // The command is kept so that the pop cycle knows which return it finishes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_cnt <= 2'h0;
      cmd <= '0;
    end else if (cmd_wr) begin
      cmd.op <= smr_pkg::smr_op_e'(pwdata[smr_pkg::CMD_OP_HI:smr_pkg::CMD_OP_LO]);
      cmd.dest <= pwdata[smr_pkg::CMD_DEST];
      cmd.lit <= pwdata[smr_pkg::CMD_LIT_HI:smr_pkg::CMD_LIT_LO];
      // Only the returns start the counter; other ops are done already
      if (ret_cmd) begin
        ret_cnt <= smr_pkg::RET_CYCLES - 2'h1; // [RULE_06] [RULE_07] [RULE_08]
      end
    end else if (ret_cnt != 2'h0) begin
      ret_cnt <= ret_cnt - 2'h1;
    end
  end

  // Program counter; the pop cycle takes priority over a software load in that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= '0;
    end else if (ret_cnt == 2'h1) begin
      // Second cycle of a return: the popped value becomes the program counter
      pc <= stack_top_value; // [RULE_06] [RULE_07] [RULE_08]
    end else if (wr_en && paddr == smr_pkg::ADDR_PC) begin
      // Software load, used to set a known starting point
      pc <= pwdata[smr_pkg::PC_W-1:0];
    end
  end

  // Stack top; one entry only, loaded by software before a return is issued
  // A deeper stack would need push logic that this unit does not have
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_top_value <= '0;
    end else if (wr_en && paddr == smr_pkg::ADDR_TOS) begin
      stack_top_value <= pwdata[smr_pkg::PC_W-1:0];
    end
  end

  // Interrupt control register
  // A software write and the hardware set may meet in one cycle: the set comes
  // last so that it wins, while the other bits of the write still land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg <= 8'h00;
    end else begin
      if (wr_en && paddr == smr_pkg::ADDR_IRQCTL) begin
        irq_control_reg <= pwdata[7:0];
      end
      if (ret_cnt == 2'h1 && cmd.op == smr_pkg::smr_rfi) begin
        irq_control_reg[smr_pkg::GIE_BIT] <= 1'b1; // [RULE_06]
      end
    end
  end

  // Read data, zero-wait answer, error on unmapped address
  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      smr_pkg::ADDR_CMD, smr_pkg::ADDR_FILE, smr_pkg::ADDR_ACC, smr_pkg::ADDR_STATUS,
      smr_pkg::ADDR_PC, smr_pkg::ADDR_TOS, smr_pkg::ADDR_IRQCTL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Bus answer: registered, so a master sees ready in its first access cycle
  // Extending the access phase is not supported; ready stands for one cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Answer arrives in the first cycle of the access phase
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      unique case (paddr)
        smr_pkg::ADDR_FILE: prdata <= {24'h000000, file_reg};
        smr_pkg::ADDR_ACC: prdata <= {24'h000000, acc};
        smr_pkg::ADDR_STATUS: prdata <= {29'h0, ret_cnt != 2'h0, zero, carry};
        smr_pkg::ADDR_PC: prdata <= {17'h0, pc};
        smr_pkg::ADDR_TOS: prdata <= {17'h0, stack_top_value};
        smr_pkg::ADDR_IRQCTL: prdata <= {24'h000000, irq_control_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Status pins straight from flip-flops
  // Busy covers both cycles of a return; single-cycle ops never raise it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
      busy <= 1'b0;
    end else begin
      global_irq_enable <= irq_control_reg[smr_pkg::GIE_BIT];
      busy <= (ret_cnt != 2'h0) || (cmd_wr && ret_cmd);
    end
  end
endmodule
`default_nettype wire

// ==== smr_core_props.sv ====
// Checker for the shift, move and return unit.
// Sees only the unit's ports; bound to every smr_core below.
`timescale 1ns/10ps
`default_nettype none
module smr_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted command write; this leaves out any made while busy, though the unit drops only those in the first busy cycle
  wire logic cmdw = psel & penable & pready & pwrite & (paddr == smr_pkg::ADDR_CMD) & !busy;
  wire logic [2:0] op = pwdata[2:0];
  property p_ack; psel && penable |-> pready; endproperty
  a_ack: assert property (p_ack) else $error("no ready");
  property p_err; psel && penable && paddr > 8'h18 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_rfi; cmdw && op == 3'h5 |-> ##[1:3] global_irq_enable; endproperty
  a_rfi: assert property (p_rfi) else $error("gie not set");
  property p_two; cmdw && op >= 3'h5 |=> busy [*2] ##1 !busy; endproperty
  a_two: assert property (p_two) else $error("return length");
  property p_one; cmdw && op != 3'h0 && op < 3'h5 |=> !busy; endproperty
  a_one: assert property (p_one) else $error("busy on shift");
  property p_keep; cmdw && op == 3'h6 |=> $stable(global_irq_enable) [*2]; endproperty
  a_keep: assert property (p_keep) else $error("gie moved");
  property p_gie; psel && pready && pwrite && paddr == smr_pkg::ADDR_IRQCTL
    |-> ##2 global_irq_enable == $past(pwdata[7], 2); endproperty
  a_gie: assert property (p_gie) else $error("gie copy");
  property p_busy; $rose(busy) |-> $past(cmdw); endproperty
  a_busy: assert property (p_busy) else $error("busy cause");
  c_rfi: cover property (cmdw && op == 3'h5);
  c_lit: cover property (cmdw && op == 3'h7);
  c_err: cover property (pready && pslverr);
endmodule
bind smr_core smr_core_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .global_irq_enable, .busy);
`default_nettype wire

// ==== tb_smr_core.sv ====
// Testbench for the shift, move and return unit.
// Drives APB itself; flags are tracked in a shadow model here.
`timescale 1ns/10ps
`default_nettype none
module tb_smr_core;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, global_irq_enable, busy, ee;
  logic cf = 1'b0, zf = 1'b0;
  logic [7:0] res, accv = 8'h00;
  int fail_count = 0, samples_checked = 0;
  always #10 pclk = ~pclk;
  smr_core u_smr_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .global_irq_enable, .busy);
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One transfer; an idle edge first keeps requests apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
    rd = prdata;
    ee = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Shift, rotate or move, then compare flags and destination
  task automatic run(input logic [2:0] op, input logic d, input logic [7:0] f);
    apb(1'b1, smr_pkg::ADDR_FILE, {24'h0, f});
    case (op)
      3'h1: {cf, res} = {f, 1'b0};
      3'h2: {res, cf} = {1'b0, f};
      3'h3: {cf, res} = {f, cf};
      default: res = f;
    endcase
    if (op != 3'h3) zf = (res == 8'h00);
    if (!d) accv = res;
    apb(1'b1, smr_pkg::ADDR_CMD, {28'h0, d, op});
    @(posedge pclk);
    chk("busy", 32'h0, {31'h0, busy});
    apb(1'b0, smr_pkg::ADDR_STATUS, 32'h0);
    chk("status", {30'h0, zf, cf}, {29'h0, rd[2:0]});
    apb(1'b0, d ? smr_pkg::ADDR_FILE : smr_pkg::ADDR_ACC, 32'h0);
    chk("dest", {24'h0, res}, rd);
  endtask
  // Return kinds: pc from stack top, flags kept, literal into acc
  task automatic ret(input logic [2:0] op, input logic [14:0] t, input logic [7:0] k);
    int n;
    apb(1'b1, smr_pkg::ADDR_TOS, {17'h0, t});
    apb(1'b1, smr_pkg::ADDR_IRQCTL, 32'h0);
    apb(1'b1, smr_pkg::ADDR_CMD, {16'h0, k, 5'h0, op});
    if (op == 3'h7) accv = k;
    @(posedge pclk);
    chk("busy", 32'h1, {31'h0, busy});
    n = 0;
    do begin
      apb(1'b0, smr_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 5);
    chk("busy", 32'h0, {31'h0, busy});
    chk("status", {30'h0, zf, cf}, {29'h0, rd[2:0]});
    apb(1'b0, smr_pkg::ADDR_PC, 32'h0);
    chk("pc", {17'h0, t}, rd);
    chk("gie", {31'h0, op == 3'h5}, {31'h0, global_irq_enable});
    apb(1'b0, smr_pkg::ADDR_ACC, 32'h0);
    chk("acc", {24'h0, accv}, rd);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("gie", 32'h0, {31'h0, global_irq_enable});
    run(3'h1, 1'b0, 8'hE6);
    run(3'h3, 1'b1, 8'hE6);
    run(3'h2, 1'b0, 8'h01);
    run(3'h4, 1'b1, 8'h00);
    run(3'h4, 1'b0, 8'h80);
    run(3'h1, 1'b1, 8'h80);
    run(3'h3, 1'b0, 8'h00);
    ret(3'h5, 15'h1234, 8'h00);
    ret(3'h6, 15'h2ABC, 8'h5A);
    ret(3'h7, 15'h7FFF, 8'hFF);
    ret(3'h7, 15'h0001, 8'h00);
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, ee});
    chk("unmapped", 32'h0, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
